/* File: adsq_pkg.sv */
// package for the converter sequencer control block
package adsq_pkg;
   localparam logic [7:0] ADDR_CTRL      = 8'h1F;
   localparam logic [7:0] ADDR_PINCFG    = 8'h9F;
   localparam logic [7:0] ADDR_RESULT    = 8'h1E;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h20;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'h21;
   localparam logic [7:0] ADDR_IRQ_CLR   = 8'h22;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [7:0] PINCFG_RESET   = 8'h00;
   localparam logic [7:0] CTRL_WMASK     = 8'hFD;
   localparam int         CTRL_ON_BIT    = 0;
   localparam int         CTRL_GO_BIT    = 2;
   localparam int         CTRL_CH_LSB    = 3;
   localparam int         CTRL_CS_LSB    = 6;
   localparam int         PINCFG_REF_BIT = 3;
   localparam logic [1:0] CS_DIV2        = 2'h0;
   localparam logic [1:0] CS_DIV8        = 2'h1;
   localparam logic [1:0] CS_DIV32       = 2'h2;
   localparam logic [1:0] CS_RC          = 2'h3;
   localparam logic [4:0] DIV2_TERM      = 5'h01;
   localparam logic [4:0] DIV8_TERM      = 5'h07;
   localparam logic [4:0] DIV32_TERM     = 5'h1F;
   localparam logic [2:0] CH_MAX         = 3'h3;
   localparam int         RES_W          = 8;
   localparam logic [2:0] SETTLE_WAIT    = 3'h3;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } adsq_bus_t;
   typedef struct packed {
      logic [1:0] clk_sel;
      logic [2:0] chan;
      logic       go;
      logic       power_on;
   } adsq_ctrl_t;
endpackage

/* File: adsq_tick.sv */
// conversion clock tick generator
`timescale 1ns/1ps
module adsq_tick
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [1:0] clk_sel,
   input  wire logic       rc_tick,
   output logic            tick
);
   logic [4:0] cnt;
   logic [4:0] term;
   assign term = (clk_sel == adsq_pkg::CS_DIV2) ? adsq_pkg::DIV2_TERM :
                 (clk_sel == adsq_pkg::CS_DIV8) ? adsq_pkg::DIV8_TERM :
                 adsq_pkg::DIV32_TERM;
   assign tick = (clk_sel == adsq_pkg::CS_RC) ? (run & rc_tick) : (run & (cnt == term));
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= 5'h00;
      else if (!run || cnt == term)
         cnt <= 5'h00;
      else
         cnt <= cnt + 5'h01;
   end
endmodule // adsq_tick

/* File: adsq_ctrl.sv */
// converter sequencer control: registers, successive approximation, pin setup
//
// Overview of operation
// - convert selected input to 8-bit result register
// - successive approximation, one bit per step
// - channel field bits 5..3 selects inputs 0..3
// - reference is supply or reference pin
// - sleep conversion only with rc clock
// - reset clears registers, powers off, aborts
// - pin configuration register sets pin functions
// - go bit set by software, hardware clears
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module adsq_ctrl
#(
   parameter int NCH = 4
)
(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic [7:0]       addr,
   input  wire logic [7:0]       wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic [7:0]            rdata,
   input  wire logic             sleep,
   input  wire logic             rc_osc_tick,
   input  wire logic             comp_in,
   output logic [1:0]            mux_sel,
   output logic                  sample_hold,
   output logic [7:0]            dac_code,
   output logic                  ref_ext_sel,
   output logic [NCH-1:0]        pin_analog,
   output logic                  analog_power,
   output logic                  irq
);
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_STEP} adsq_state_t;

   adsq_pkg::adsq_bus_t  bus;
   adsq_pkg::adsq_ctrl_t ctrl;
   adsq_state_t          state;
   logic [7:0]           pincfg;
   logic [7:0]           result;
   logic [7:0]           trial;
   logic [2:0]           bitpos;
   logic [2:0]           settle;
   logic                 step_tick;
   logic [1:0]           irq_stat;
   logic [1:0]           irq_en;
   logic                 comp_s1;
   logic                 comp_s2;
   logic                 rc_s1;
   logic                 rc_s2;
   logic                 rc_d;
   logic                 tick;
   logic                 run;
   logic                 allowed;
   logic                 done_ev;
   logic                 abort_ev;
   logic                 wr_ctrl;
   logic                 wr_pin;
   logic                 wr_en;
   logic                 wr_clr;
   logic                 start_req;
   logic [7:0]           ctrl_rd;
   logic [7:0]           next_rdata;
   logic [7:0]           step_mask;
   logic [7:0]           next_trial;

   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign wr_ctrl = bus.wr && bus.addr == adsq_pkg::ADDR_CTRL;
   assign wr_pin  = bus.wr && bus.addr == adsq_pkg::ADDR_PINCFG;
   assign wr_en   = bus.wr && bus.addr == adsq_pkg::ADDR_IRQ_EN;
   assign wr_clr  = bus.wr && bus.addr == adsq_pkg::ADDR_IRQ_CLR;
   assign start_req = wr_ctrl && bus.wdata[adsq_pkg::CTRL_GO_BIT]
                      && bus.wdata[adsq_pkg::CTRL_ON_BIT];

   // sleep only stops the divided core clock ticks, not the rc clock
   assign allowed = !sleep || ctrl.clk_sel == adsq_pkg::CS_RC;
   assign run = (state != ST_IDLE) && allowed;
   assign analog_power = ctrl.power_on;
   // a power-off write aborts on its own edge so sampling stops at once
   assign abort_ev = (state != ST_IDLE) && (!ctrl.power_on
                     || (wr_ctrl && !bus.wdata[adsq_pkg::CTRL_ON_BIT]));
   // comparator answer crosses its flop and two sync stages before use
   assign step_tick = tick && settle == 3'h0;
   assign done_ev = (state == ST_STEP) && step_tick && bitpos == 3'h0 && !abort_ev;

   // bit 1 unimplemented, reads zero
   assign ctrl_rd = {ctrl.clk_sel, ctrl.chan, ctrl.go, 1'b0, ctrl.power_on};
   assign next_rdata =
      (bus.addr == adsq_pkg::ADDR_CTRL)     ? ctrl_rd :
      (bus.addr == adsq_pkg::ADDR_PINCFG)   ? pincfg :
      (bus.addr == adsq_pkg::ADDR_RESULT)   ? result :
      (bus.addr == adsq_pkg::ADDR_IRQ_STAT) ? {6'h00, irq_stat} :
      (bus.addr == adsq_pkg::ADDR_IRQ_EN)   ? {6'h00, irq_en} : 8'h00;

   assign step_mask = 8'h01 << bitpos;
   // keep trial bit when comparator says input is at or above dac level
   assign next_trial = (comp_s2 ? trial : (trial & ~step_mask))
                       | ((bitpos != 3'h0) ? (step_mask >> 1) : 8'h00);

   assign mux_sel = (ctrl.chan > adsq_pkg::CH_MAX) ? 2'h0 : ctrl.chan[1:0];
   assign ref_ext_sel = pincfg[adsq_pkg::PINCFG_REF_BIT];
   assign sample_hold = (state == ST_SAMPLE);
   assign dac_code = trial;
   assign irq = |(irq_stat & irq_en);

   // pin function decode from the configuration register
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_pin
         assign pin_analog[gi] = pincfg[gi];
      end
   endgenerate

   adsq_tick u_tick
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .run      (run),
      .clk_sel  (ctrl.clk_sel),
      .rc_tick  (rc_s2 & ~rc_d),
      .tick     (tick)
   );

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         comp_s1 <= 1'b0;
         comp_s2 <= 1'b0;
         rc_s1   <= 1'b0;
         rc_s2   <= 1'b0;
         rc_d    <= 1'b0;
      end
      else
      begin
         comp_s1 <= comp_in;
         comp_s2 <= comp_s1;
         rc_s1   <= rc_osc_tick;
         rc_s2   <= rc_s1;
         rc_d    <= rc_s2;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl   <= adsq_pkg::adsq_ctrl_t'({adsq_pkg::CTRL_RESET[7:2],
                                           adsq_pkg::CTRL_RESET[0]});
         pincfg <= adsq_pkg::PINCFG_RESET;
         irq_en <= 2'h0;
         rdata  <= 8'h00;
      end
      else
      begin
         rdata <= bus.rd ? next_rdata : 8'h00;
         if (wr_pin)
            pincfg <= bus.wdata;
         if (wr_en)
            irq_en <= bus.wdata[1:0];
         if (wr_ctrl)
         begin
            ctrl.clk_sel  <= bus.wdata[adsq_pkg::CTRL_CS_LSB +: 2];
            ctrl.chan     <= bus.wdata[adsq_pkg::CTRL_CH_LSB +: 3];
            ctrl.power_on <= bus.wdata[adsq_pkg::CTRL_ON_BIT];
         end
         if (start_req && state == ST_IDLE)
            ctrl.go <= 1'b1;
         else if (done_ev || abort_ev)
            ctrl.go <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state  <= ST_IDLE;
         trial  <= 8'h00;
         bitpos <= 3'h0;
         result <= 8'h00;
         settle <= 3'h0;
      end
      else
      begin
         if (settle != 3'h0)
            settle <= settle - 3'h1;
         case (state)
            ST_IDLE:
               if (start_req)
               begin
                  state  <= ST_SAMPLE;
                  trial  <= 8'h80;
                  bitpos <= 3'(adsq_pkg::RES_W - 1);
               end
            ST_SAMPLE:
               if (abort_ev)
                  state <= ST_IDLE;
               else if (tick)
               begin
                  state  <= ST_STEP;
                  settle <= adsq_pkg::SETTLE_WAIT;
               end
            ST_STEP:
               if (abort_ev)
                  state <= ST_IDLE;
               else if (step_tick)
               begin
                  trial  <= next_trial;
                  bitpos <= bitpos - 3'h1;
                  settle <= adsq_pkg::SETTLE_WAIT;
                  if (bitpos == 3'h0)
                  begin
                     result <= next_trial;
                     state  <= ST_IDLE;
                  end
               end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // bit0 done, bit1 abort; set wins over clear
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat <= 2'h0;
      else
         irq_stat <= (irq_stat & ~(wr_clr ? bus.wdata[1:0] : 2'h0)) | {abort_ev, done_ev};
   end
endmodule // adsq_ctrl

/* File: adsq_ctrl_props.sv */
// port checker for the converter control block
`timescale 1ns/1ps
module adsq_ctrl_props
#(
   parameter int NCH = 4
)
(
   input wire logic           core_clk,
   input wire logic           rst_n,
   input wire logic [7:0]     addr,
   input wire logic [7:0]     wdata,
   input wire logic           wr,
   input wire logic           rd,
   input wire logic [7:0]     rdata,
   input wire logic [1:0]     mux_sel,
   input wire logic           sample_hold,
   input wire logic           ref_ext_sel,
   input wire logic [NCH-1:0] pin_analog,
   input wire logic           analog_power,
   input wire logic           irq,
   input wire logic [7:0]     dac_code
);
   wire wc = wr && addr == adsq_pkg::ADDR_CTRL;
   wire wp = wr && addr == adsq_pkg::ADDR_PINCFG;
   wire rc = rd && addr == adsq_pkg::ADDR_CTRL;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_off_wr;
      wc && !wdata[0];
   endsequence
   sequence s_rd_ctrl;
      !wr ##1 rc && !wr;
   endsequence
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_power_follow: assert property (wc |=> analog_power == $past(wdata[0]))
      else $error("power does not follow control bit 0");
   a_pin_cfg: assert property (wp |=> pin_analog == $past(wdata[NCH-1:0])
      && ref_ext_sel == $past(wdata[3]))
      else $error("pin setup does not follow write");
   a_mux_sel: assert property (wc && wdata[5:3] <= adsq_pkg::CH_MAX |=>
      mux_sel == $past(wdata[4:3]))
      else $error("channel select wrong");
   a_mux_clamp: assert property (wc && wdata[5:3] > adsq_pkg::CH_MAX |=>
      mux_sel == 2'h0)
      else $error("unused channel not mapped to input 0");
   a_bit1_zero: assert property (rc |=> !rdata[1])
      else $error("control bit 1 read as one");
   a_ctrl_back: assert property (s_off_wr ##1 s_rd_ctrl |=>
      rdata == {$past(wdata[7:3], 3), 3'h0})
      else $error("control readback after power off wrong");
   a_abort_idle: assert property (wc && !wdata[0] |=> !sample_hold)
      else $error("sampling continues after power off");
   a_irq_off: assert property (wr && wdata == 8'h00 &&
      addr == adsq_pkg::ADDR_IRQ_EN |=> !irq)
      else $error("interrupt high with nothing enabled");
   a_unmapped_read: assert property (rd && addr[7:6] == 2'h1 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_sar_start: assert property (sample_hold |-> dac_code == 8'h80)
      else $error("trial code not at midscale while sampling");
endmodule // adsq_ctrl_props

/* File: adsq_afe.sv */
// analog front end model: input mux, sample and hold, comparator
`timescale 1ns/1ps
module adsq_afe
(
   input wire logic        core_clk,
   input wire logic [31:0] vin,
   input wire logic [1:0]  mux_sel,
   input wire logic        sample_hold,
   input wire logic        analog_power,
   input wire logic [7:0]  dac_code,
   output logic            comp_in
);
   logic [7:0] held;
   initial comp_in = 1'h0;
   always @(posedge core_clk)
   begin
      if (sample_hold)
         held <= vin[mux_sel*8 +: 8];
      comp_in <= analog_power ? held >= dac_code : ~comp_in;
   end
endmodule // adsq_afe

/* File: testbench.sv */
// testbench for the converter control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
   logic        core_clk = 0, rst_n = 0, wr = 0, rd = 0, sleep = 0, rc_osc_tick = 0;
   logic        rd_d = 0, sample_hold, ref_ext_sel, analog_power, irq, comp_in;
   logic [7:0]  addr = '0, wdata = '0, rdata, dac_code, e;
   logic [31:0] vin = '0;
   logic [1:0]  mux_sel;
   logic [3:0]  pin_analog;
   int          n_mismatch = 0, checks_done = 0, cyc = 0, seed = 32'h5CC9;
   logic [7:0]  exp_q[$];
   always #10 core_clk = ~core_clk;
   always #160 rc_osc_tick = ~rc_osc_tick;
   adsq_ctrl #(.NCH(4)) DUT (.core_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .sleep,
      .rc_osc_tick, .comp_in, .mux_sel, .sample_hold, .dac_code, .ref_ext_sel,
      .pin_analog, .analog_power, .irq);
   adsq_afe u_afe (.core_clk, .vin, .mux_sel, .sample_hold, .analog_power, .dac_code,
      .comp_in);
   task conclude;
      if (n_mismatch == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      rd_d <= rd;
      cyc++;
      if (rd_d)
      begin
         e = exp_q.pop_front();
         `CHK("rdata", e, rdata)
      end
      if (cyc == 30000)
      begin
         n_mismatch++;
         conclude();
      end
   end
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      if (!w)
         exp_q.push_back(d);
      @(posedge core_clk);
      wr <= 1'h0;
      rd <= 1'h0;
      @(posedge core_clk);
   endtask
   task conv(input logic [1:0] cs, input logic [2:0] ch, input logic slp,
      input logic [7:0] v);
      logic [31:0] r;
      r = {4{~v}};
      r[ch[1:0]*8 +: 8] = v;
      vin <= r;
      sleep <= slp;
      bus(1, adsq_pkg::ADDR_CTRL, {cs, ch, 3'h5});
      if (slp && cs != adsq_pkg::CS_RC)
      begin
         repeat (300) @(posedge core_clk);
         bus(0, adsq_pkg::ADDR_IRQ_STAT, 8'h00);
         bus(0, adsq_pkg::ADDR_CTRL, {cs, ch, 3'h5});
         sleep <= 1'h0;
      end
      for (int i = 0; i < 3000 && irq !== 1'h1; i++)
         @(posedge core_clk);
      sleep <= 1'h0;
      bus(0, adsq_pkg::ADDR_RESULT, v);
      bus(0, adsq_pkg::ADDR_CTRL, {cs, ch, 3'h1});
      bus(0, adsq_pkg::ADDR_IRQ_STAT, 8'h01);
      bus(1, adsq_pkg::ADDR_IRQ_CLR, 8'h01);
   endtask
   initial
   begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'h1;
      @(posedge core_clk);
      bus(0, adsq_pkg::ADDR_CTRL, 8'h00);
      bus(0, adsq_pkg::ADDR_PINCFG, 8'h00);
      bus(0, 8'h55, 8'h00);
      bus(1, adsq_pkg::ADDR_PINCFG, 8'h08);
      bus(0, adsq_pkg::ADDR_PINCFG, 8'h08);
      bus(1, adsq_pkg::ADDR_PINCFG, 8'h07);
      bus(0, adsq_pkg::ADDR_PINCFG, 8'h07);
      bus(1, adsq_pkg::ADDR_CTRL, 8'h06);
      bus(0, adsq_pkg::ADDR_CTRL, 8'h00);
      bus(1, adsq_pkg::ADDR_CTRL, 8'h28);
      bus(0, adsq_pkg::ADDR_CTRL, 8'h28);
      bus(1, adsq_pkg::ADDR_IRQ_EN, 8'h03);
      conv(2'h0, 3'h0, 1'h0, 8'hFF);
      for (int k = 1; k < 4; k++)
         conv(k[1:0], k[2:0], 1'h0, 8'($random(seed)));
      conv(adsq_pkg::CS_DIV8, 3'h0, 1'h1, 8'($random(seed)));
      conv(adsq_pkg::CS_RC, 3'h3, 1'h1, 8'($random(seed)));
      bus(1, adsq_pkg::ADDR_CTRL, 8'h8D);
      repeat (40) @(posedge core_clk);
      bus(1, adsq_pkg::ADDR_CTRL, 8'h88);
      bus(0, adsq_pkg::ADDR_CTRL, 8'h88);
      bus(0, adsq_pkg::ADDR_IRQ_STAT, 8'h02);
      bus(1, adsq_pkg::ADDR_IRQ_EN, 8'h00);
      bus(0, adsq_pkg::ADDR_IRQ_EN, 8'h00);
      bus(1, adsq_pkg::ADDR_IRQ_EN, 8'h03);
      bus(1, adsq_pkg::ADDR_IRQ_CLR, 8'h02);
      bus(1, adsq_pkg::ADDR_CTRL, 8'h4D);
      repeat (20) @(posedge core_clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'h1;
      @(posedge core_clk);
      bus(0, adsq_pkg::ADDR_CTRL, 8'h00);
      bus(0, adsq_pkg::ADDR_PINCFG, 8'h00);
      bus(0, adsq_pkg::ADDR_IRQ_STAT, 8'h00);
      conclude();
   end
endmodule // testbench
bind adsq_ctrl adsq_ctrl_props #(.NCH(NCH)) u_props (.core_clk, .rst_n, .addr, .wdata, .wr,
   .rd, .rdata, .mux_sel, .sample_hold, .dac_code, .ref_ext_sel, .pin_analog, .analog_power,
   .irq);
